// ==== inc/rsrb_pkg.sv ====
// Shared constants and carrier types for the receive status readback bank
package rsrb_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IF_GAIN_W = 7;

  // Read-only status offsets
  localparam logic [7:0] OFS_TEST_BUS = 8'h64;
  localparam logic [7:0] OFS_SIG_QUAL = 8'h66;
  localparam logic [7:0] OFS_RX_SIGNAL = 8'h68;
  localparam logic [7:0] OFS_RX_SERVICE = 8'h6A;
  localparam logic [7:0] OFS_LEN_LOW = 8'h6C;
  localparam logic [7:0] OFS_LEN_HIGH = 8'h6E;
  localparam logic [7:0] OFS_CRC_LOW = 8'h70;
  localparam logic [7:0] OFS_CRC_HIGH = 8'h72;
  localparam logic [7:0] OFS_TX_POWER = 8'h74;
  localparam logic [7:0] OFS_MEAN_POWER = 8'h78;
  localparam logic [7:0] OFS_IF_GAIN = 8'h7A;

  // Writable controls that steer this bank
  localparam logic [7:0] OFS_MP_THRESH = 8'h48;
  localparam logic [7:0] OFS_VIEW_SEL = 8'h62;

  // Field positions
  localparam int VIEW_SEL_BIT = 7;
  localparam int MP_THR_MSB = 7;
  localparam int MP_THR_LSB = 5;

  // Reset values
  localparam logic [7:0] RST_VIEW_SEL = 8'h00;
  localparam logic [7:0] RST_MP_THRESH = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;

  // Counts
  localparam int MP_WINDOW = 15;
  localparam int TXP_AVG_LOG2 = 6;

  typedef enum logic {
    RSRB_VIEW_B,
    RSRB_VIEW_A
  } rsrb_view_e;

  // Fields captured from a received header
  typedef struct packed {
    logic [7:0] signal_f;
    logic [7:0] service_f;
    logic [15:0] length_f;
    logic [15:0] crc_f;
  } rsrb_hdr_s;

  // Measurements from the demodulator datapath
  typedef struct packed {
    logic [7:0] noise_a;
    logic [7:0] noise_b;
    logic [7:0] dc_i;
    logic [7:0] dc_q;
    logic [7:0] mp_metric;
    logic [7:0] pkt_quality;
    logic [7:0] hdr_quality;
    logic [7:0] snr_quality;
  } rsrb_meas_s;

endpackage

// ==== hw/rsrb_bank.sv ====
// Receive and transmit status readback bank with dual-view register mux
// Contract
// - View bit one shows a, zero shows b
// - Test bus register returns live test bus
// - Reg 51: noise A or loop SNR quality
// - Reg 52: noise B or signal field
// - Reg 53: I DC offset or service field
// - Reg 54: Q DC offset or length low
// - Reg 55: multipath metric or length high
// - Reg 56: multipath count or CRC low
// - Reg 57 view b: header CRC high
// - Reg 57 view a: packet quality, read after packet
// - Reg 58: signed transmit power, 64-sample average
// - Reg 60 view a: header quality, read after packet
// - Reg 60 view b: received mean power in dB
// - Reg 61: seven-bit IF gain, bit 7 zero
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

module rsrb_bank #(
  parameter int MP_DEPTH = rsrb_pkg::MP_WINDOW,
  parameter int TXP_LOG2 = rsrb_pkg::TXP_AVG_LOG2
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic [rsrb_pkg::ADDR_W-1:0] ADDR,
  input wire logic [rsrb_pkg::DATA_W-1:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [rsrb_pkg::DATA_W-1:0] RDATA,
  input wire logic [7:0] TEST_BUS,
  input wire rsrb_pkg::rsrb_meas_s MEAS,
  input wire rsrb_pkg::rsrb_hdr_s HDR,
  input wire logic HDR_VALID,
  input wire logic RX_PACKET_ACTIVE,
  input wire logic [7:0] TX_POWER_SAMPLE,
  input wire logic TX_POWER_VALID,
  input wire logic [7:0] RX_MEAN_POWER,
  input wire logic [rsrb_pkg::IF_GAIN_W-1:0] IF_GAIN_CONTROL_OUTPUT,
  output logic VIEW_A
);

  localparam int ACC_W = 8 + TXP_LOG2;
  localparam int CNT_W = $clog2(MP_DEPTH + 1);

  // Counts ones in the multipath history
  function automatic logic [CNT_W-1:0] ones_count(input logic [MP_DEPTH-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < MP_DEPTH; i++) begin
      n = n + CNT_W'(v[i]);
    end
    return n;
  endfunction

  logic [7:0] view_sel_reg;
  logic [7:0] mp_thresh_reg;
  rsrb_pkg::rsrb_view_e view;
  rsrb_pkg::rsrb_hdr_s hdr_reg;
  logic active_d_reg;
  logic pkt_end;
  logic [7:0] mp_metric_reg;
  logic [7:0] pkt_quality_reg;
  logic [7:0] hdr_quality_reg;
  logic [MP_DEPTH-1:0] mp_hist_reg;
  logic [MP_DEPTH-1:0] mp_hist_next;
  logic [CNT_W-1:0] mp_count_reg;
  logic mp_exceed;
  logic signed [ACC_W-1:0] txp_acc_reg;
  logic signed [ACC_W-1:0] txp_sum;
  logic [TXP_LOG2-1:0] txp_cnt_reg;
  logic [7:0] txp_avg_reg;
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;

  // Software-written controls; only these two offsets take writes
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      view_sel_reg <= rsrb_pkg::RST_VIEW_SEL;
      mp_thresh_reg <= rsrb_pkg::RST_MP_THRESH;
    end else if (WR_STB) begin
      if (ADDR == rsrb_pkg::OFS_VIEW_SEL) begin
        view_sel_reg <= WDATA;
      end
      if (ADDR == rsrb_pkg::OFS_MP_THRESH) begin
        mp_thresh_reg <= WDATA;
      end
    end
  end

  // Mux select taken from the top bit of the seed register
  assign view = rsrb_pkg::rsrb_view_e'(view_sel_reg[rsrb_pkg::VIEW_SEL_BIT]);
  assign VIEW_A = (view == rsrb_pkg::RSRB_VIEW_A);

  // Header fields held from one valid header to the next
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      hdr_reg <= '0;
    end else if (HDR_VALID) begin
      hdr_reg <= HDR;
    end
  end

  // Packet end is the falling edge of the packet-active level
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      active_d_reg <= 1'b0;
    end else begin
      active_d_reg <= RX_PACKET_ACTIVE;
    end
  end

  assign pkt_end = active_d_reg && !RX_PACKET_ACTIVE;

  // Per-packet metrics are frozen at packet end, so a read after the
  // packet never sees a half-updated figure from the next one
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      mp_metric_reg <= rsrb_pkg::RST_STATUS;
      pkt_quality_reg <= rsrb_pkg::RST_STATUS;
      hdr_quality_reg <= rsrb_pkg::RST_STATUS;
    end else if (pkt_end) begin
      mp_metric_reg <= MEAS.mp_metric;
      pkt_quality_reg <= MEAS.pkt_quality;
      hdr_quality_reg <= MEAS.hdr_quality;
    end
  end

  // A packet counts when its metric class is above the threshold field
  assign mp_exceed = MEAS.mp_metric[rsrb_pkg::MP_THR_MSB:rsrb_pkg::MP_THR_LSB] >
                     mp_thresh_reg[rsrb_pkg::MP_THR_MSB:rsrb_pkg::MP_THR_LSB];
  assign mp_hist_next = {mp_hist_reg[MP_DEPTH-2:0], mp_exceed};

  // Sliding window of the most recent packets
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      mp_hist_reg <= '0;
      mp_count_reg <= '0;
    end else if (pkt_end) begin
      mp_hist_reg <= mp_hist_next;
      mp_count_reg <= ones_count(mp_hist_next);
    end
  end

  assign txp_sum = txp_acc_reg + ACC_W'(signed'(TX_POWER_SAMPLE));

  // Block average: result moves only once per full set of samples,
  // trading update rate for a steady reading
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      txp_acc_reg <= '0;
      txp_cnt_reg <= '0;
      txp_avg_reg <= rsrb_pkg::RST_STATUS;
    end else if (TX_POWER_VALID) begin
      txp_cnt_reg <= txp_cnt_reg + 1'b1;
      if (&txp_cnt_reg) begin
        txp_avg_reg <= txp_sum[ACC_W-1:TXP_LOG2];
        txp_acc_reg <= '0;
      end else begin
        txp_acc_reg <= txp_sum;
      end
    end
  end

  // Read mux; unmapped offsets read zero, the two control offsets read back their values
  always_comb begin
    rd_mux = 8'h00;
    case (ADDR)
      rsrb_pkg::OFS_TEST_BUS: begin
        rd_mux = TEST_BUS;
      end
      rsrb_pkg::OFS_SIG_QUAL: begin
        rd_mux = VIEW_A ? MEAS.noise_a : MEAS.snr_quality;
      end
      rsrb_pkg::OFS_RX_SIGNAL: begin
        rd_mux = VIEW_A ? MEAS.noise_b : hdr_reg.signal_f;
      end
      rsrb_pkg::OFS_RX_SERVICE: begin
        rd_mux = VIEW_A ? MEAS.dc_i : hdr_reg.service_f;
      end
      rsrb_pkg::OFS_LEN_LOW: begin
        rd_mux = VIEW_A ? MEAS.dc_q : hdr_reg.length_f[7:0];
      end
      rsrb_pkg::OFS_LEN_HIGH: begin
        rd_mux = VIEW_A ? mp_metric_reg : hdr_reg.length_f[15:8];
      end
      rsrb_pkg::OFS_CRC_LOW: begin
        rd_mux = VIEW_A ? 8'(mp_count_reg) : hdr_reg.crc_f[7:0];
      end
      rsrb_pkg::OFS_CRC_HIGH: begin
        rd_mux = VIEW_A ? pkt_quality_reg : hdr_reg.crc_f[15:8];
      end
      rsrb_pkg::OFS_TX_POWER: begin
        rd_mux = txp_avg_reg;
      end
      rsrb_pkg::OFS_MEAN_POWER: begin
        rd_mux = VIEW_A ? hdr_quality_reg : RX_MEAN_POWER;
      end
      rsrb_pkg::OFS_IF_GAIN: begin
        rd_mux = {1'b0, IF_GAIN_CONTROL_OUTPUT};
      end
      rsrb_pkg::OFS_VIEW_SEL: begin
        rd_mux = view_sel_reg;
      end
      rsrb_pkg::OFS_MP_THRESH: begin
        rd_mux = mp_thresh_reg;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
    end else if (RD_STB) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;

  // View a of register 51 follows the antenna A noise floor
  a_view_a_noise: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_SIG_QUAL && VIEW_A
    |=> RDATA == $past(MEAS.noise_a))
    else $error("view a of signal quality is not noise A");

  // View b of register 51 follows the loop SNR quality
  a_view_b_snr: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_SIG_QUAL && !view_sel_reg[7]
    |=> RDATA == $past(MEAS.snr_quality))
    else $error("view b of signal quality is wrong");

  // Test bus reads live in either view
  a_test_bus_read: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_TEST_BUS
    |=> RDATA == $past(TEST_BUS))
    else $error("test bus readback mismatch");

  // Length high byte in view b
  a_len_high_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_LEN_HIGH && !VIEW_A
    |=> RDATA == $past(hdr_reg.length_f[15:8]))
    else $error("length high byte mismatch");

  // IF gain register keeps bit 7 at zero
  a_if_gain_msb: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_IF_GAIN
    |=> RDATA[7] == 1'b0 && RDATA[6:0] == $past(IF_GAIN_CONTROL_OUTPUT))
    else $error("IF gain readback wrong");

  // Average moves only on the last sample of a block
  a_txp_avg_hold: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    !$stable(txp_avg_reg)
    |-> $past(TX_POWER_VALID) && $past(txp_cnt_reg) == '1)
    else $error("transmit power average moved mid-block");

  // Multipath count is the ones of the window and never exceeds it
  a_mp_count_ok: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    mp_count_reg == ones_count(mp_hist_reg) && mp_count_reg <= MP_DEPTH)
    else $error("multipath count out of step with history");

  // Per-packet quality holds while a packet is active
  a_quality_hold: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RX_PACKET_ACTIVE ##1 RX_PACKET_ACTIVE
    |-> $stable(pkt_quality_reg) && $stable(hdr_quality_reg))
    else $error("quality metric changed during packet");

  // Writes to status offsets leave the controls untouched
  a_write_ignored: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    WR_STB && ADDR != rsrb_pkg::OFS_VIEW_SEL && ADDR != rsrb_pkg::OFS_MP_THRESH
    |=> $stable(view_sel_reg) && $stable(mp_thresh_reg))
    else $error("status write disturbed a control register");

  // Read data is zero outside the answer cycle
  a_rdata_idle: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    !RD_STB |=> RDATA == 8'h00)
    else $error("read data stands outside its cycle");

  // Writing the seed register moves the view with its top bit
  a_view_write_bit: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    WR_STB && ADDR == rsrb_pkg::OFS_VIEW_SEL
    |=> VIEW_A == $past(WDATA[rsrb_pkg::VIEW_SEL_BIT]))
    else $error("view select did not follow the written bit");

  // Register 52 in view a shows the antenna B noise floor
  a_noise_b_view: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_RX_SIGNAL && VIEW_A
    |=> RDATA == $past(MEAS.noise_b))
    else $error("view a of signal field is not noise B");

  // Register 52 in view b shows the captured signal field
  a_signal_field_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_RX_SIGNAL && !VIEW_A
    |=> RDATA == $past(hdr_reg.signal_f))
    else $error("signal field readback mismatch");

  // Register 53 in view a shows the in-phase offset
  a_dc_i_view: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_RX_SERVICE && VIEW_A
    |=> RDATA == $past(MEAS.dc_i))
    else $error("in-phase offset readback mismatch");

  // Register 53 in view b shows the captured service field
  a_service_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_RX_SERVICE && !VIEW_A
    |=> RDATA == $past(hdr_reg.service_f))
    else $error("service field readback mismatch");

  // Register 54 in view a shows the quadrature offset
  a_dc_q_view: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_LEN_LOW && VIEW_A
    |=> RDATA == $past(MEAS.dc_q))
    else $error("quadrature offset readback mismatch");

  // Register 54 in view b shows the length low byte
  a_len_low_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_LEN_LOW && !VIEW_A
    |=> RDATA == $past(hdr_reg.length_f[7:0]))
    else $error("length low byte mismatch");

  // Frozen metric, so a read long after the packet still matches it
  a_mp_metric_a: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_LEN_HIGH && VIEW_A
    |=> RDATA == $past(mp_metric_reg))
    else $error("multipath metric readback mismatch");

  // Register 56 in view b shows the header CRC low byte
  a_crc_low_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_CRC_LOW && !VIEW_A
    |=> RDATA == $past(hdr_reg.crc_f[7:0]))
    else $error("header CRC low byte mismatch");

  // Register 57 in view b shows the header CRC high byte
  a_crc_high_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_CRC_HIGH && !VIEW_A
    |=> RDATA == $past(hdr_reg.crc_f[15:8]))
    else $error("header CRC high byte mismatch");

  // Register 57 in view a shows the frozen packet quality
  a_pkt_quality_a: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_CRC_HIGH && VIEW_A
    |=> RDATA == $past(pkt_quality_reg))
    else $error("packet quality readback mismatch");

  // Transmit power reads the same average in both views
  a_tx_power_read: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_TX_POWER
    |=> RDATA == $past(txp_avg_reg))
    else $error("transmit power readback mismatch");

  // Register 60 in view b passes the live mean power
  a_mean_power_b: assert property (
    @(posedge CLOCK) disable iff (!RESET_N)
    RD_STB && ADDR == rsrb_pkg::OFS_MEAN_POWER && !VIEW_A
    |=> RDATA == $past(RX_MEAN_POWER))
    else $error("mean power readback mismatch");

endmodule

// ==== sim/rsrb_host.sv ====
// Host controller model that drives the status bank register bus
`timescale 1ns/1ps

module rsrb_host (
  input wire logic CLOCK,
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR_STB,
  output logic RD_STB,
  input wire logic [7:0] RDATA
);
  // Bus idles with both strobes low
  initial begin
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
  end

  // One-cycle write; the address is scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WR_STB <= 1'b1;
    @(posedge CLOCK);
    WR_STB <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask

  // One-cycle read; data are only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge CLOCK);
    RD_STB <= 1'b0;
    ADDR <= ~a;
    #1 d = RDATA;
  endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the receive status readback bank
`timescale 1ns/1ps

module testbench;
  logic clock, reset_n, hdr_valid, rx_pkt, txv, wr_stb, rd_stb, view_a;
  logic [7:0] addr, wdata, rdata, test_bus, txs, mean_pw, d, thr, tx_avg;
  logic [7:0] cap_mp, cap_pq, cap_hq;
  logic [6:0] ifg;
  logic [31:0] seed = 32'hDCD1;
  rsrb_pkg::rsrb_meas_s meas;
  rsrb_pkg::rsrb_hdr_s hdr, hdr_c;
  bit hist[$];
  int fails, checked, cycles;
  logic [7:0] ofs[12] = '{8'h64, 8'h66, 8'h68, 8'h6A, 8'h6C, 8'h6E, 8'h70, 8'h72, 8'h74,
    8'h78, 8'h7A, 8'h7C};

  rsrb_bank u_rsrb_bank (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .TEST_BUS(test_bus), .MEAS(meas),
    .HDR(hdr), .HDR_VALID(hdr_valid), .RX_PACKET_ACTIVE(rx_pkt), .TX_POWER_SAMPLE(txs),
    .TX_POWER_VALID(txv), .RX_MEAN_POWER(mean_pw), .IF_GAIN_CONTROL_OUTPUT(ifg),
    .VIEW_A(view_a));
  rsrb_host u_rsrb_host (.CLOCK(clock), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
    .RD_STB(rd_stb), .RDATA(rdata));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected register value from the view and the bench's own history
  function automatic logic [7:0] expv(input logic va, input logic [7:0] a);
    int n;
    n = 0;
    foreach (hist[i]) n += hist[i];
    case (a)
      8'h64: return test_bus;
      8'h66: return va ? meas.noise_a : meas.snr_quality;
      8'h68: return va ? meas.noise_b : hdr_c.signal_f;
      8'h6A: return va ? meas.dc_i : hdr_c.service_f;
      8'h6C: return va ? meas.dc_q : hdr_c.length_f[7:0];
      8'h6E: return va ? cap_mp : hdr_c.length_f[15:8];
      8'h70: return va ? 8'(n) : hdr_c.crc_f[7:0];
      8'h72: return va ? cap_pq : hdr_c.crc_f[15:8];
      8'h74: return tx_avg;
      8'h78: return va ? cap_hq : mean_pw;
      8'h7A: return {1'b0, ifg};
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Fresh live inputs, then every status offset and unmapped 7C read and compared
  task automatic sweep(input logic va);
    @(posedge clock);
    test_bus <= 8'(xs());
    mean_pw <= 8'(xs());
    ifg <= 7'(xs());
    foreach (ofs[i]) begin
      u_rsrb_host.rd(ofs[i], d);
      chk($sformatf("reg %h", ofs[i]), expv(va, ofs[i]), d);
    end
  endtask

  // Packet metrics are read only after packet active has fallen
  task automatic pkt();
    @(posedge clock);
    rx_pkt <= 1'b1;
    meas <= {xs(), xs()};
    repeat (3) @(posedge clock);
    rx_pkt <= 1'b0;
    @(posedge clock);
    cap_mp = meas.mp_metric;
    cap_pq = meas.pkt_quality;
    cap_hq = meas.hdr_quality;
    hist.push_back(meas.mp_metric[7:5] > thr[7:5]);
    if (hist.size() > 15) void'(hist.pop_front());
    meas <= {xs(), xs()};
  endtask

  // Sixty-four samples; a corner run holds the most negative value
  task automatic txrun(input bit corner);
    int sum;
    logic [7:0] smp;
    sum = 0;
    repeat (64) begin
      @(posedge clock);
      smp = corner ? 8'h80 : 8'(xs());
      txs <= smp;
      txv <= 1'b1;
      sum += $signed(smp);
    end
    @(posedge clock);
    txv <= 1'b0;
    tx_avg = 8'(sum >>> 6);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    {reset_n, hdr_valid, rx_pkt, txv, txs, test_bus, mean_pw, ifg, thr, tx_avg} = '0;
    {meas, hdr, hdr_c, cap_mp, cap_pq, cap_hq} = '0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1 chk("view after reset", 8'h00, {7'h00, view_a});
    sweep(1'b0);
    $display("test reset done");
    @(posedge clock);
    hdr_c = 48'({xs(), xs()});
    hdr <= hdr_c;
    hdr_valid <= 1'b1;
    @(posedge clock);
    hdr_valid <= 1'b0;
    hdr <= ~hdr_c;
    foreach (ofs[i]) u_rsrb_host.wr(ofs[i], 8'hFF);
    sweep(1'b0);
    u_rsrb_host.rd(8'h64, d);
    @(posedge clock);
    #1 chk("rdata release", 8'h00, rdata);
    $display("test header and ignored writes done");
    // Threshold class 3 keeps both outcomes of the window likely
    thr = {3'h3, 5'(xs())};
    u_rsrb_host.wr(8'h48, thr);
    repeat (17) pkt();
    txrun(1'b1);
    u_rsrb_host.wr(8'h62, 8'h80);
    #1 chk("view a", 8'h01, {7'h00, view_a});
    sweep(1'b1);
    txrun(1'b0);
    pkt();
    sweep(1'b1);
    u_rsrb_host.wr(8'h62, 8'h00);
    sweep(1'b0);
    $display("test packets and power done");
    final_report();
  end
endmodule
